// file: src/ldr_pkg.sv
// package: register map, field layout and reset values of the regulator control bank
package ldr_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [7:0] LDR_ADDR_LDO_THREE = 8'h70;
  localparam logic [7:0] LDR_ADDR_LDO_FOUR = 8'h71;
  localparam logic [7:0] LDR_ADDR_PAGE = 8'h7f;
  localparam int LDR_EXT_BIT = 7;
  localparam logic [7:0] LDR_READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // field positions of a regulator control register
  // ----------------------------------------------------------------
  localparam int LDR_F_SLEEP = 7;
  localparam int LDR_F_LPWR = 6;
  localparam int LDR_F_STBY = 5;
  localparam int LDR_F_ON = 4;
  localparam int LDR_F_VHI = 3;
  localparam int LDR_F_VLO = 0;
  localparam int LDR_PAGE_HI = 3;

  // ----------------------------------------------------------------
  // page encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] LDR_PAGE_FUNC = 4'h0;
  localparam logic [3:0] LDR_PAGE_EXT1 = 4'h1;
  localparam logic [3:0] LDR_PAGE_EXT2 = 4'h2;
  localparam logic [7:0] LDR_PAGE_RST = 8'h00;
  localparam logic [7:0] LDR_CTL_RST = 8'h00;
  localparam int LDR_EXT_WORDS = 128;

  // one regulator's decoded control
  typedef struct packed {
    logic turnoff_sleep_sel;
    logic lowpower_allow;
    logic standby_off;
    logic on;
    logic [3:0] voltage_code;
  } ldr_ctl_t;

  // one register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldr_acc_t;

endpackage

// file: src/ldr_ext_page.sv
// extended-page storage: two banks of upper-half registers, picked by page
`timescale 1ns/1ps
module ldr_ext_page
  import ldr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [1:0] bank,
  input wire logic [6:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // ----------------------------------------------------------------
  // storage, one array per extended page
  // ----------------------------------------------------------------
  logic [7:0] mem_ff [2][LDR_EXT_WORDS];
  logic [0:0] sel;

  // bank 1 is page 1, bank 2 is page 2; other values are masked by the
  // caller, which blocks writes and zeroes reads for them
  always_comb begin
    sel = bank[1];
  end

  // reset clears everything so reads are defined
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < LDR_EXT_WORDS; i++) begin
          mem_ff[b][i] <= LDR_READ_ZERO;
        end
      end
    end else if (wr) begin
      mem_ff[sel][idx] <= wdata;
    end
  end

  // read is combinational; the top registers it
  always_comb begin
    rdata = mem_ff[sel][idx];
  end

endmodule

// file: src/ldr_regbank.sv
// top: regulator control registers, page select and paged address decode
`timescale 1ns/1ps

// Contract
// [RL1] bit 7: turn-off goes sleep when set
// [RL2] bit 6: low-power mode allowed when set
// [RL3] bit 5: off in standby when set
// [RL4] bit 4: regulator enable
// [RL5] bits 3:0: output voltage code
// [RL6] page 0 functional, 1 and 2 extended
// [RL7] host selects page before extended access
// [RL8] 0x00-0x7f functional, 0x80-0xff extended
// [RL9] functional registers identical on every page
// [RL10] functional range reachable from any page
// [RL11] reserved addresses read zero, ignore writes
// [RL12] eight-bit address and eight-bit data
// [RL13] write one clears, zero leaves unchanged (no such field here; control writes store the whole byte, page writes store its low nibble)
// [RL14] fuse defaults loaded, then host writable
// [RL15] control and page registers always accessible
// [RL16] unsupported page: extended reads zero
// [RL17] reset returns page to functional
module ldr_regbank
  import ldr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] fuse_ldo_three,
  input wire logic [7:0] fuse_ldo_four,
  input wire logic fuse_load,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output ldr_ctl_t reg_a_ctl,
  output ldr_ctl_t reg_b_ctl,
  output logic [3:0] page_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ldr_acc_t acc;
  logic [7:0] ctl_a_ff, nxt_ctl_a;
  logic [7:0] ctl_b_ff, nxt_ctl_b;
  logic [7:0] page_ff, nxt_page;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic ext_hit, ext_ok, ext_wr;
  logic [1:0] ext_bank;
  logic [7:0] ext_rdata;

  // bundle the access; address and data are bytes throughout
  assign acc = '{wr: acc_wr, rd: acc_rd, addr: acc_addr, wdata: acc_wdata}; // [RL12]

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // top address bit alone splits the map, so the functional half
  // never depends on the page value
  always_comb begin
    ext_hit = acc.addr[LDR_EXT_BIT]; // [RL8] [RL9] [RL10]
    ext_ok = (page_ff[LDR_PAGE_HI:0] == LDR_PAGE_EXT1) ||
             (page_ff[LDR_PAGE_HI:0] == LDR_PAGE_EXT2); // [RL6] [RL7]
    ext_wr = acc.wr && ext_hit && ext_ok; // [RL16]
    ext_bank = page_ff[1:0];
  end

  ldr_ext_page u_ext (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(ext_wr),
    .bank(ext_bank),
    .idx(acc.addr[6:0]),
    .wdata(acc.wdata),
    .rdata(ext_rdata)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // fuse load wins over a functional-range host write in the same cycle; the host is
  // expected to wait until start-up has finished
  always_comb begin
    nxt_ctl_a = ctl_a_ff;
    nxt_ctl_b = ctl_b_ff;
    nxt_page = page_ff;
    if (fuse_load) begin
      nxt_ctl_a = fuse_ldo_three; // [RL14]
      nxt_ctl_b = fuse_ldo_four; // [RL14]
    end else if (acc.wr && !ext_hit) begin
      // no mode lockout: writes land whenever presented
      case (acc.addr)
        LDR_ADDR_LDO_THREE: nxt_ctl_a = acc.wdata; // [RL15] [RL1] [RL2] [RL3] [RL4] [RL5]
        LDR_ADDR_LDO_FOUR: nxt_ctl_b = acc.wdata; // [RL15]
        LDR_ADDR_PAGE: nxt_page = {4'h0, acc.wdata[LDR_PAGE_HI:0]}; // [RL15]
        default: nxt_ctl_a = ctl_a_ff; // [RL11] reserved: no effect
      endcase
    end
  end

  // reset puts page back on the functional encoding
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_a_ff <= LDR_CTL_RST;
      ctl_b_ff <= LDR_CTL_RST;
      page_ff <= LDR_PAGE_RST; // [RL17]
    end else begin
      ctl_a_ff <= nxt_ctl_a;
      ctl_b_ff <= nxt_ctl_b;
      page_ff <= nxt_page;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // no write-one-to-clear field lives in this bank, so reads are plain
  always_comb begin
    nxt_rvalid = acc.rd;
    nxt_rdata = rdata_ff;
    if (acc.rd) begin
      if (ext_hit) begin
        nxt_rdata = ext_ok ? ext_rdata : LDR_READ_ZERO; // [RL16]
      end else begin
        case (acc.addr)
          LDR_ADDR_LDO_THREE: nxt_rdata = ctl_a_ff;
          LDR_ADDR_LDO_FOUR: nxt_rdata = ctl_b_ff;
          LDR_ADDR_PAGE: nxt_rdata = page_ff;
          default: nxt_rdata = LDR_READ_ZERO; // [RL11] [RL13]
        endcase
      end
    end
  end

  // answer is registered so it stands a full cycle after the strobe,
  // and read data holds until the next read replaces it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= LDR_READ_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops
  // ----------------------------------------------------------------
  // the upper page nibble is stored as zero, reads back as zero and is left off page_sel
  assign acc_rdata = rdata_ff;
  assign acc_rvalid = rvalid_ff;
  assign reg_a_ctl = ctl_a_ff; // [RL1] [RL2] [RL3] [RL4] [RL5]
  assign reg_b_ctl = ctl_b_ff;
  assign page_sel = page_ff[LDR_PAGE_HI:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ctl_write_lands: assert property (@(posedge mclk) disable iff (!rst_n) // [RL15]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_THREE |=> reg_a_ctl == $past(acc.wdata))
    else $error("control write lost");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [RL11]
    acc.rd && !acc.addr[7] && acc.addr != LDR_ADDR_PAGE && acc.addr != LDR_ADDR_LDO_THREE
    && acc.addr != LDR_ADDR_LDO_FOUR |=> acc_rvalid && acc_rdata == 8'h00)
    else $error("reserved read not zero");
  a_bad_page_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [RL16]
    acc.rd && acc.addr[7] && page_sel > 4'h2 |=> acc_rdata == 8'h00)
    else $error("unsupported page read not zero");
  a_page_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RL6]
    acc.wr && acc.addr == LDR_ADDR_PAGE |=> page_sel == $past(acc.wdata[3:0]))
    else $error("page write lost");
  a_func_any_page: assert property (@(posedge mclk) disable iff (!rst_n) // [RL10]
    acc.rd && acc.addr == LDR_ADDR_LDO_FOUR |=> acc_rdata == $past(reg_b_ctl))
    else $error("functional read depends on page");
  a_fuse_load: assert property (@(posedge mclk) disable iff (!rst_n) // [RL14]
    fuse_load |=> reg_a_ctl == $past(fuse_ldo_three) && reg_b_ctl == $past(fuse_ldo_four))
    else $error("fuse default not loaded");
  a_ext_no_func: assert property (@(posedge mclk) disable iff (!rst_n) // [RL8]
    acc.wr && acc.addr[7] && !fuse_load |=> $stable(reg_a_ctl) && $stable(page_sel))
    else $error("extended write hit functional register");
  a_read_strobe: assert property (@(posedge mclk) disable iff (!rst_n) // [RL12]
    acc.rd |=> acc_rvalid ##1 (acc_rvalid == $past(acc.rd)))
    else $error("read answer timing wrong");

  // field mapping: each bit written to LDR_ADDR_LDO_FOUR must reach its own decoded output in reg_b_ctl,
  // which catches a struct order that drifts from the field positions
  a_sleep_field: assert property (@(posedge mclk) disable iff (!rst_n) // [RL1]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_FOUR
    |=> reg_b_ctl.turnoff_sleep_sel == $past(acc.wdata[LDR_F_SLEEP]))
    else $error("sleep select bit misplaced");
  a_lowpower_field: assert property (@(posedge mclk) disable iff (!rst_n) // [RL2]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_FOUR
    |=> reg_b_ctl.lowpower_allow == $past(acc.wdata[LDR_F_LPWR]))
    else $error("low-power allow bit misplaced");
  a_standby_field: assert property (@(posedge mclk) disable iff (!rst_n) // [RL3]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_FOUR
    |=> reg_b_ctl.standby_off == $past(acc.wdata[LDR_F_STBY]))
    else $error("standby off bit misplaced");
  a_enable_field: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_FOUR
    |=> reg_b_ctl.on == $past(acc.wdata[LDR_F_ON]))
    else $error("enable bit misplaced");
  a_voltage_field: assert property (@(posedge mclk) disable iff (!rst_n) // [RL5]
    acc.wr && !fuse_load && acc.addr == LDR_ADDR_LDO_FOUR
    |=> reg_b_ctl.voltage_code == $past(acc.wdata[LDR_F_VHI:LDR_F_VLO]))
    else $error("voltage code misplaced");

  // reserved writes, idle strobes and the functional page must all be
  // side-effect free towards the host
  a_reserved_no_write: assert property (@(posedge mclk) disable iff (!rst_n) // [RL11]
    acc.wr && !fuse_load && !acc.addr[LDR_EXT_BIT] && acc.addr != LDR_ADDR_PAGE
    && acc.addr != LDR_ADDR_LDO_THREE && acc.addr != LDR_ADDR_LDO_FOUR
    |=> $stable(reg_a_ctl) && $stable(reg_b_ctl) && $stable(page_sel))
    else $error("reserved write changed a register");
  a_rvalid_idle: assert property (@(posedge mclk) disable iff (!rst_n) // [RL12]
    !acc.rd |=> !acc_rvalid)
    else $error("read answer without a read");
  a_page_zero_ext: assert property (@(posedge mclk) disable iff (!rst_n) // [RL17]
    acc.rd && acc.addr[LDR_EXT_BIT] && page_sel == LDR_PAGE_FUNC |=> acc_rdata == LDR_READ_ZERO)
    else $error("extended read on functional page not zero");

endmodule

// file: verification/ldr_host_model.sv
// host model: single-byte register reads and writes
`timescale 1ns/1ps
module ldr_host_model
  import ldr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid,
  output logic acc_wr,
  output logic acc_rd,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata
);
  // idle bus at time zero
  initial begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
  end
  // one strobe per byte; idle lines flip so stale values never match
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    acc_wr = w;
    acc_rd = !w;
    acc_addr = a;
    acc_wdata = d;
    @(posedge mclk);
    #1;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask
  // caller writes the page byte before extended access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
  // answer is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    put(1'b0, a, ~a);
    d = acc_rdata;
    v = acc_rvalid;
  endtask
endmodule

// file: verification/test_ldr_regbank.sv
// testbench: random and hand-picked traffic against a reference map
`timescale 1ns/1ps
module test_ldr_regbank
  import ldr_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fuse_load = 1'b0;
  logic [7:0] fuse_ldo_three = 8'h00;
  logic [7:0] fuse_ldo_four = 8'h00;
  logic acc_wr, acc_rd, acc_rvalid;
  logic [7:0] acc_addr, acc_wdata, acc_rdata, ra, rb, pg, a, wd;
  logic [7:0] e1 [128];
  logic [7:0] e2 [128];
  ldr_ctl_t reg_a_ctl, reg_b_ctl;
  logic [3:0] page_sel;
  logic [31:0] seed = 32'h5326;
  logic [31:0] r;
  int err_count = 0;
  int comparisons = 0;
  // 4 ns clock
  always #2 mclk = ~mclk;
  ldr_regbank ldr_regbank_inst (.mclk(mclk), .rst_n(rst_n), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .fuse_ldo_three(fuse_ldo_three), .fuse_ldo_four(fuse_ldo_four),
    .fuse_load(fuse_load), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .reg_a_ctl(reg_a_ctl), .reg_b_ctl(reg_b_ctl), .page_sel(page_sel));
  ldr_host_model ldr_host_model_inst (.mclk(mclk), .acc_rdata(acc_rdata),
    .acc_rvalid(acc_rvalid), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata));
  // ----
  // reference map
  // ----
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    if (x == LDR_ADDR_LDO_THREE) return ra;
    if (x == LDR_ADDR_LDO_FOUR) return rb;
    if (x == LDR_ADDR_PAGE) return pg;
    if (x[7] && pg == 8'h01) return e1[x[6:0]];
    if (x[7] && pg == 8'h02) return e2[x[6:0]];
    return LDR_READ_ZERO;
  endfunction
  task clr_mdl;
    ra = 8'h00;
    rb = 8'h00;
    pg = 8'h00;
    foreach (e1[i]) begin
      e1[i] = 8'h00;
      e2[i] = 8'h00;
    end
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write, mirror it, then compare every register output
  task do_wr(input logic [7:0] x, input logic [7:0] d);
    ldr_host_model_inst.wr(x, d);
    if (x == LDR_ADDR_LDO_THREE) ra = d;
    else if (x == LDR_ADDR_LDO_FOUR) rb = d;
    else if (x == LDR_ADDR_PAGE) pg = {4'h0, d[3:0]};
    else if (x[7] && pg == 8'h01) e1[x[6:0]] = d;
    else if (x[7] && pg == 8'h02) e2[x[6:0]] = d;
    chk(reg_a_ctl, ra);
    chk(reg_b_ctl, rb);
    chk({4'h0, page_sel}, pg);
  endtask
  task do_rd(input logic [7:0] x);
    logic [7:0] d;
    logic v;
    ldr_host_model_inst.rd(x, d, v);
    chk(d, exp_rd(x));
    chk({7'h00, v}, 8'h01);
  endtask
  task wrap_up;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    clr_mdl();
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({4'h0, page_sel}, LDR_PAGE_RST);
    do_rd(LDR_ADDR_LDO_THREE);
    $display("test reset done");
    r = xs();
    @(posedge mclk);
    #1;
    fuse_ldo_three = r[7:0];
    fuse_ldo_four = r[15:8];
    fuse_load = 1'b1;
    @(posedge mclk);
    #1 fuse_load = 1'b0;
    ra = r[7:0];
    rb = r[15:8];
    do_rd(LDR_ADDR_LDO_THREE);
    do_rd(LDR_ADDR_LDO_FOUR);
    $display("test fuse done");
    // one-hot walk puts each field bit alone
    for (int i = 0; i < 8; i++) do_wr(LDR_ADDR_LDO_FOUR, 8'h01 << i);
    do_wr(LDR_ADDR_PAGE, 8'hf1);
    do_wr(8'h85, 8'haa);
    do_wr(LDR_ADDR_PAGE, 8'h02);
    do_wr(8'h85, 8'h55);
    do_rd(LDR_ADDR_LDO_FOUR);
    do_wr(LDR_ADDR_PAGE, 8'h03);
    do_wr(8'h85, 8'h11);
    do_rd(8'h85);
    do_wr(LDR_ADDR_PAGE, 8'h01);
    do_rd(8'h85);
    do_wr(8'h72, 8'hff);
    do_rd(8'h72);
    $display("test pages done");
    // random mix, page field kept mostly in the decoded range
    repeat (400) begin
      r = xs();
      case (r[1:0])
        2'd0: a = {7'h38, r[8]};
        2'd1: a = LDR_ADDR_PAGE;
        2'd2: a = {1'b1, r[14:8]};
        default: a = r[15:8];
      endcase
      wd = (a == LDR_ADDR_PAGE) ? {r[23:20], 2'b00, r[17:16]} : r[23:16];
      if (r[31]) do_wr(a, wd);
      else do_rd(a);
    end
    $display("test random done");
    @(posedge mclk);
    #1 rst_n = 1'b0;
    clr_mdl();
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({4'h0, page_sel}, LDR_PAGE_RST);
    do_rd(8'h85);
    do_rd(LDR_ADDR_LDO_THREE);
    $display("test second reset done");
    wrap_up();
  end
  // tests need about 900 cycles; 12500 is ample
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
endmodule
